// ### pkg/pmss_map.svh
`ifndef PMSS_MAP_SVH
`define PMSS_MAP_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PMSS_CLK_MHZ    40
`define PMSS_STEP_US    300
`define PMSS_STEP_CYC   (`PMSS_STEP_US * `PMSS_CLK_MHZ)
`define PMSS_RAMP_NS0   12500
`define PMSS_RAMP_NS1   25000
`define PMSS_RAMP_NS2   50000
`define PMSS_RAMP_NS3   100000
`define PMSS_RAMP_CYC(ns) (((ns) * `PMSS_CLK_MHZ) / 1000)
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMSS_ADR_PWR    6'h00
`define PMSS_ADR_REG    6'h0b
`define PMSS_ADR_MOD3   6'h15
`define PMSS_ADR_STAT   6'h2a
`define PMSS_ADR_IRQ    6'h38
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PMSS_PWR_STBY   7
`define PMSS_PWR_FIELD  6
`define PMSS_RVS_LSB    0
`define PMSS_PA_LSB     4
`define PMSS_RAMP_LSB   0
`define PMSS_LIN_BIT    2
`define PMSS_STAT_OSC   0
`define PMSS_STAT_RDY   1
`define PMSS_IRQ_CMD    0
`define PMSS_IRQ_ANA    1
`define PMSS_RST_PWR    8'h00
`define PMSS_RST_REG    8'h77
`define PMSS_RST_MOD3   8'h00
// ----------------------------------------
// Commands and voltage codes
// ----------------------------------------
`define PMSS_CMD_AUTO   8'ha2
`define PMSS_CMD_MAN    8'ha3
`define PMSS_CODE_MAX   3'h7
`define PMSS_CODE_MIN   3'h0
`endif

// ### pkg/pmss_pkg.sv
package pmss_pkg;
  typedef enum logic [3:0] {
    pm_pdown = 4'h1,
    pm_stby  = 4'h2,
    pm_norm  = 4'h4,
    pm_field = 4'h8
  } pmss_mode_t;
  typedef enum logic [3:0] {
    rp_off  = 4'h1,
    rp_up   = 4'h2,
    rp_on   = 4'h4,
    rp_down = 4'h8
  } pmss_ramp_t;
  typedef enum logic [2:0] {
    au_idle = 3'h1,
    au_hold = 3'h2,
    au_done = 3'h4
  } pmss_auto_t;
  typedef struct packed {
    logic [2:0] main_sel;
    logic [2:0] pa_sel;
  } pmss_supply_t;
endpackage

// ### hdl/pmss_sequencer.sv
`timescale 1ns/100ps
`include "pmss_map.svh"
// Contract
// RULE1: Main regulator level from three-bit code, 2.7 V to 3.4 V, 0.1 V steps.
// RULE2: PA regulator takes the lower of its manual code and the automatic level.
// RULE3: Command A2h starts automatic level search; A3h returns to manual levels.
// RULE4: Host locks PLL within 840 to 960 MHz before issuing A2h.
// RULE5: Automatic search starts at 3.4 V with the RF field switched on.
// RULE6: Search lowers level 100 mV per 300 us step, never below 2.7 V.
// RULE7: Search ends when supply exceeds level by 300 mV or lowest step reached.
// RULE8: At search end the field goes off and command-done flag raises interrupt.
// RULE9: Enable pin low holds power-down with all circuitry disabled.
// RULE10: Standby bit in normal mode puts analog into low power, RF paths off; a running search still turns the field on in standby.
// RULE11: Register contents survive standby entry and exit.
// RULE12: Host waits about 12 ms after leaving standby before RF use.
// RULE13: Enable high starts normal mode; host waits about 12 ms before access.
// RULE14: Read-only oscillator-stable flag in 2Ah; host polls it before use.
// RULE15: Host waits about 500 ms after clock stable before RF and inventory.
// RULE16: Field-enable bit starts ramp-up at once, timed and shaped by 15h.
// RULE17: Ramp-up done sets field-ready flag and analog-event interrupt flag.
// RULE18: Ramp-down on clear, same settings; then field-ready clears, event flag.
// RULE19: Mode decode from enable pin, standby bit and field-enable bit.
// RULE20: Host allows 12 to 17 ms from power-down or standby for normal mode.
// RULE21: Pending interrupt drives the interrupt request output high.
// RULE22: Step timer runs from reference clock; enable low aborts the search.
module pmss_sequencer #(
  parameter int STEP_CYCLES = `PMSS_STEP_CYC
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                en,
  input  wire logic                osc_stable,
  input  wire logic                ext_margin_ok,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [5:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                cmd_valid,
  input  wire logic [7:0]          cmd_code,
  output logic [7:0]               reg_rdata,
  output pmss_pkg::pmss_supply_t   supply,
  output pmss_pkg::pmss_mode_t     mode,
  output logic                     circuits_en,
  output logic                     low_power,
  output logic                     field_on,
  output logic                     ramp_linear,
  output logic                     irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]           pwr_ctrl;
  logic [7:0]           reg_bias;
  logic [7:0]           mod_ctrl3;
  logic                 osc_ok;
  logic                 field_ready;
  logic [1:0]           irq_flags;
  pmss_pkg::pmss_ramp_t ramp_st;
  pmss_pkg::pmss_auto_t auto_st;
  logic [2:0]           auto_code;
  logic                 auto_en;
  logic [13:0]          step_timer;
  logic [11:0]          ramp_timer;
  logic                 stby_bit;
  logic                 fen_bit;
  logic                 wr_ok;
  logic                 auto_start;
  logic                 auto_finish;
  logic                 ramp_up_done;
  logic                 ramp_dn_done;
  logic                 field_req;
  logic [11:0]          ramp_len;
  logic [2:0]           pa_manual;
  logic [2:0]           next_main;
  logic [2:0]           next_pa;

  localparam logic [13:0] STEP_LOAD = 14'(STEP_CYCLES - 1);

  assign stby_bit     = pwr_ctrl[`PMSS_PWR_STBY];
  assign fen_bit      = pwr_ctrl[`PMSS_PWR_FIELD];
  assign wr_ok        = reg_wr && en;
  assign auto_start   = cmd_valid && en && cmd_code == `PMSS_CMD_AUTO; // RULE3
  assign auto_finish  = auto_st == pmss_pkg::au_hold && step_timer == 14'h0000
                        && (ext_margin_ok || auto_code == `PMSS_CODE_MIN); // RULE7
  assign ramp_up_done = ramp_st == pmss_pkg::rp_up && ramp_timer == 12'h000;
  assign ramp_dn_done = ramp_st == pmss_pkg::rp_down && ramp_timer == 12'h000;
  // Search forces a load on the supply regardless of the field bit
  assign field_req    = en && ((fen_bit && !stby_bit) || auto_st == pmss_pkg::au_hold); // RULE5
  assign pa_manual    = reg_bias[`PMSS_PA_LSB +: 3];

  always_comb begin
    case (mod_ctrl3[`PMSS_RAMP_LSB +: 2]) // RULE16
      2'b00:   ramp_len = 12'(`PMSS_RAMP_CYC(`PMSS_RAMP_NS0) - 1);
      2'b01:   ramp_len = 12'(`PMSS_RAMP_CYC(`PMSS_RAMP_NS1) - 1);
      2'b10:   ramp_len = 12'(`PMSS_RAMP_CYC(`PMSS_RAMP_NS2) - 1);
      default: ramp_len = 12'(`PMSS_RAMP_CYC(`PMSS_RAMP_NS3) - 1);
    endcase
  end

  always_comb begin
    next_main = auto_en ? auto_code : reg_bias[`PMSS_RVS_LSB +: 3]; // RULE1
    next_pa   = pa_manual;
    if (auto_en && auto_code < pa_manual) begin
      next_pa = auto_code; // RULE2
    end
  end

  // ----------------------------------------
  // Register file; enable low restores defaults
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_ctrl  <= `PMSS_RST_PWR;
      reg_bias  <= `PMSS_RST_REG;
      mod_ctrl3 <= `PMSS_RST_MOD3;
    end else if (!en) begin
      pwr_ctrl  <= `PMSS_RST_PWR; // RULE9
      reg_bias  <= `PMSS_RST_REG;
      mod_ctrl3 <= `PMSS_RST_MOD3;
    end else if (wr_ok) begin
      // Standby changes nothing here, so settings survive it
      case (reg_addr) // RULE11
        `PMSS_ADR_PWR:  pwr_ctrl  <= reg_wdata;
        `PMSS_ADR_REG:  reg_bias  <= reg_wdata;
        `PMSS_ADR_MOD3: mod_ctrl3 <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_ok <= 1'b0;
    end else begin
      osc_ok <= en && osc_stable; // RULE14
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && en) begin
      case (reg_addr)
        `PMSS_ADR_PWR:  reg_rdata <= pwr_ctrl;
        `PMSS_ADR_REG:  reg_rdata <= reg_bias;
        `PMSS_ADR_MOD3: reg_rdata <= mod_ctrl3;
        `PMSS_ADR_STAT: reg_rdata <= {6'h00, field_ready, osc_ok}; // RULE14
        `PMSS_ADR_IRQ:  reg_rdata <= {6'h00, irq_flags};
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupt flags: clear on read, set wins
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_flags <= 2'b00;
    end else if (!en) begin
      irq_flags <= 2'b00;
    end else begin
      if (reg_rd && reg_addr == `PMSS_ADR_IRQ) begin
        irq_flags <= 2'b00;
      end
      if (auto_finish) begin
        irq_flags[`PMSS_IRQ_CMD] <= 1'b1; // RULE8
      end
      if (ramp_up_done || ramp_dn_done) begin
        irq_flags[`PMSS_IRQ_ANA] <= 1'b1; // RULE17 RULE18
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |irq_flags; // RULE21
    end
  end

  // ----------------------------------------
  // Automatic supply level search
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      auto_st    <= pmss_pkg::au_idle;
      auto_code  <= `PMSS_CODE_MAX;
      auto_en    <= 1'b0;
      step_timer <= 14'h0000;
    end else if (!en) begin
      auto_st    <= pmss_pkg::au_idle; // RULE22
      auto_code  <= `PMSS_CODE_MAX;
      auto_en    <= 1'b0;
      step_timer <= 14'h0000;
    end else if (auto_start) begin
      auto_st    <= pmss_pkg::au_hold; // RULE3 RULE5
      auto_code  <= `PMSS_CODE_MAX;
      auto_en    <= 1'b1;
      step_timer <= STEP_LOAD;
    end else if (cmd_valid && cmd_code == `PMSS_CMD_MAN) begin
      auto_st <= pmss_pkg::au_idle; // RULE3
      auto_en <= 1'b0;
    end else begin
      case (auto_st)
        pmss_pkg::au_hold: begin
          if (auto_finish) begin
            auto_st <= pmss_pkg::au_done;
          end else if (step_timer == 14'h0000) begin
            auto_code  <= auto_code - 3'h1; // RULE6
            step_timer <= STEP_LOAD;
          end else begin
            step_timer <= step_timer - 14'h0001; // RULE22
          end
        end
        pmss_pkg::au_done: auto_st <= pmss_pkg::au_done;
        pmss_pkg::au_idle: auto_st <= pmss_pkg::au_idle;
        default:           auto_st <= pmss_pkg::au_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply <= '{main_sel: `PMSS_CODE_MAX, pa_sel: `PMSS_CODE_MAX};
    end else begin
      supply <= '{main_sel: next_main, pa_sel: next_pa};
    end
  end

  // ----------------------------------------
  // Field ramp
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_st    <= pmss_pkg::rp_off;
      ramp_timer <= 12'h000;
    end else if (!en) begin
      ramp_st    <= pmss_pkg::rp_off;
      ramp_timer <= 12'h000;
    end else begin
      case (ramp_st)
        pmss_pkg::rp_off: begin
          if (field_req) begin
            ramp_st    <= pmss_pkg::rp_up; // RULE16
            ramp_timer <= ramp_len;
          end
        end
        pmss_pkg::rp_up: begin
          if (ramp_timer == 12'h000) begin
            ramp_st <= pmss_pkg::rp_on;
          end else begin
            ramp_timer <= ramp_timer - 12'h001;
          end
        end
        pmss_pkg::rp_on: begin
          if (!field_req) begin
            ramp_st    <= pmss_pkg::rp_down; // RULE18 RULE8
            ramp_timer <= ramp_len;
          end
        end
        pmss_pkg::rp_down: begin
          if (ramp_timer == 12'h000) begin
            ramp_st <= pmss_pkg::rp_off;
          end else begin
            ramp_timer <= ramp_timer - 12'h001;
          end
        end
        default: ramp_st <= pmss_pkg::rp_off;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      field_ready <= 1'b0;
    end else if (!en || ramp_dn_done) begin
      field_ready <= 1'b0; // RULE18
    end else if (ramp_up_done) begin
      field_ready <= 1'b1; // RULE17
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      field_on    <= 1'b0;
      ramp_linear <= 1'b0;
    end else begin
      field_on    <= en && ramp_st != pmss_pkg::rp_off;
      ramp_linear <= mod_ctrl3[`PMSS_LIN_BIT];
    end
  end

  // ----------------------------------------
  // Power mode
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode        <= pmss_pkg::pm_pdown;
      circuits_en <= 1'b0;
      low_power   <= 1'b0;
    end else begin
      circuits_en <= en; // RULE9 RULE13
      low_power   <= en && stby_bit; // RULE10
      if (!en) begin
        mode <= pmss_pkg::pm_pdown; // RULE19
      end else if (stby_bit) begin
        mode <= pmss_pkg::pm_stby;
      end else if (fen_bit) begin
        mode <= pmss_pkg::pm_field;
      end else begin
        mode <= pmss_pkg::pm_norm;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_main_manual: assert property (en && !auto_en |=> supply.main_sel == $past(reg_bias[2:0])) // RULE1
    else $error("main level not from manual code");
  chk_pa_lowest: assert property (auto_en ##1 auto_en |-> supply.pa_sel <= $past(auto_code)
                                  && supply.pa_sel <= $past(pa_manual)) // RULE2
    else $error("pa level not the lower one");
  chk_auto_start: assert property (auto_start |=> auto_code == 3'h7 && field_req ##2 field_on) // RULE5
    else $error("search start wrong");
  chk_step_down: assert property (en && auto_st == pmss_pkg::au_hold && !auto_start && !cmd_valid
                                  && step_timer == 14'h0000 && !auto_finish
                                  |=> !en || auto_code == $past(auto_code) - 3'h1) // RULE6
    else $error("hold end did not step down");
  chk_step_size: assert property (en && !auto_start && auto_code != $past(auto_code)
                                  && $past(en) && !$past(auto_start) && $past(en, 1)
                                  |-> auto_code == $past(auto_code) - 3'h1
                                  && $past(step_timer) == 14'h0000) // RULE6
    else $error("step not one code after hold");
  chk_auto_end: assert property (auto_finish && en |=> irq_flags[0] ##1 irq) // RULE8
    else $error("search end did not flag");
  chk_pdown: assert property (!en |=> mode == pmss_pkg::pm_pdown && !circuits_en
                              && auto_st == pmss_pkg::au_idle) // RULE9
    else $error("power-down not held");
  chk_mode_stby: assert property (en && stby_bit |=> mode == pmss_pkg::pm_stby && low_power) // RULE19
    else $error("standby decode wrong");
  chk_ramp_ready: assert property (ramp_up_done && en |=> field_ready && irq_flags[1]) // RULE17
    else $error("ramp-up end not flagged");
  chk_irq_level: assert property (|irq_flags |=> irq) // RULE21
    else $error("irq not raised");

  cov_auto_done: cover property (auto_st == pmss_pkg::au_hold ##1 auto_st == pmss_pkg::au_done);
  cov_ramp_cycle: cover property (ramp_up_done ##[1:1000] ramp_dn_done);
  cov_stby: cover property (mode == pmss_pkg::pm_field ##[1:20] mode == pmss_pkg::pm_stby);
endmodule

// ### tb/pmss_host_model.sv
`timescale 1ns/100ps
`include "pmss_map.svh"
module pmss_host_model #(
  parameter int SETTLE_CYC = 40
) (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            en,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            cmd_valid,
  output logic [7:0]      cmd_code
);
  // ----------------------------------------
  // Host side of pin and register traffic
  // ----------------------------------------
  initial begin
    en = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end
  // Released address and data flip so stale values never match by luck
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    reg_addr = ~a;
  endtask
  // Synthesiser taken as locked in band before any auto request
  task automatic cmd(input logic [7:0] c);
    @(negedge clk);
    cmd_code = c;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
  endtask
  // Settle times scaled down; real parts need milliseconds
  task automatic power_up();
    logic [7:0] d;
    int         n;
    @(negedge clk);
    en = 1'b1;
    repeat (SETTLE_CYC) @(negedge clk);
    n = 0;
    d = 8'h00;
    while (d[`PMSS_STAT_OSC] !== 1'b1 && n < 100) begin
      rd(`PMSS_ADR_STAT, d);
      n++;
    end
    repeat (SETTLE_CYC) @(negedge clk);
  endtask
  task automatic power_down();
    @(negedge clk);
    en = 1'b0;
  endtask
  task automatic stby_exit();
    wr(`PMSS_ADR_PWR, 8'h00);
    repeat (SETTLE_CYC) @(negedge clk);
  endtask
endmodule

// ### tb/pmss_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "pmss_map.svh"
module pmss_sequencer_tb_top;
  localparam int STEP = 20;
  logic                   clk, arst_n, osc_stable, ext_margin_ok, en, reg_wr, reg_rd;
  logic                   cmd_valid, circuits_en, low_power, field_on, ramp_linear, irq;
  logic [5:0]             reg_addr;
  logic [7:0]             reg_wdata, cmd_code, reg_rdata, d;
  logic [2:0]             mm, pm, ex;
  logic [15:0]            lfsr;
  pmss_pkg::pmss_supply_t supply;
  pmss_pkg::pmss_mode_t   mode;
  int                     mismatches, checks, cyc, n, kk, c0, i;
  pmss_sequencer #(.STEP_CYCLES(STEP)) dut_u (.clk(clk), .arst_n(arst_n), .en(en),
    .osc_stable(osc_stable), .ext_margin_ok(ext_margin_ok), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .reg_rdata(reg_rdata), .supply(supply), .mode(mode),
    .circuits_en(circuits_en), .low_power(low_power), .field_on(field_on),
    .ramp_linear(ramp_linear), .irq(irq));
  pmss_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .en(en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Comparator stands in for supply headroom: met at codes up to kk
  always @(negedge clk) ext_margin_ok <= (int'(supply.main_sel) <= kk);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    osc_stable = 1'b0;
    kk = -1;
    mismatches = 0;
    checks = 0;
    cyc = 0;
    lfsr = 16'h3b1b;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("mode", {4'h0, mode}, {4'h0, pmss_pkg::pm_pdown});
    check("circuits", {7'h00, circuits_en}, 8'h00);
    osc_stable = 1'b1;
    host_u.power_up();
    check("mode", {4'h0, mode}, {4'h0, pmss_pkg::pm_norm});
    check("circuits", {7'h00, circuits_en}, 8'h01);
    host_u.wr(`PMSS_ADR_STAT, 8'hff);
    host_u.rd(`PMSS_ADR_STAT, d);
    check("status", d, 8'h01);
    host_u.rd(`PMSS_ADR_REG, d);
    check("reg bias", d, `PMSS_RST_REG);
    host_u.rd(`PMSS_ADR_MOD3, d);
    check("mod3", d, `PMSS_RST_MOD3);
    host_u.rd(6'h3f, d);
    check("unmapped", d, 8'h00);
    // Manual codes, random
    repeat (6) begin
      lfsr = lfsr_next(lfsr);
      host_u.wr(`PMSS_ADR_REG, lfsr[7:0] & 8'h77);
      @(negedge clk);
      check("supply", {2'b00, supply}, {2'b00, lfsr[2:0], lfsr[6:4]});
    end
    host_u.wr(`PMSS_ADR_PWR, 8'h80);
    repeat (2) @(negedge clk);
    check("mode", {4'h0, mode}, {4'h0, pmss_pkg::pm_stby});
    check("low power", {7'h00, low_power}, 8'h01);
    host_u.stby_exit();
    check("low power", {7'h00, low_power}, 8'h00);
    host_u.rd(`PMSS_ADR_REG, d);
    check("reg kept", d, lfsr[7:0] & 8'h77);
    // Field ramps over all four times, shape toggled
    for (int t = 0; t < 4; t++) begin
      host_u.wr(`PMSS_ADR_MOD3, 8'(t) | (8'(t % 2) << `PMSS_LIN_BIT));
      host_u.wr(`PMSS_ADR_PWR, 8'h40);
      // Ramp state moves one edge after the write, field output one edge later
      repeat (2) @(negedge clk);
      check("shape", {7'h00, ramp_linear}, 8'(t % 2));
      check("field", {7'h00, field_on}, 8'h01);
      check("mode", {4'h0, mode}, {4'h0, pmss_pkg::pm_field});
      wait_irq(5000);
      check("ramp up", 8'(n >= (500 << t) - 6 && n <= (500 << t) + 6), 8'h01);
      host_u.rd(`PMSS_ADR_STAT, d);
      check("ready", d, 8'h03);
      host_u.rd(`PMSS_ADR_IRQ, d);
      check("irq flags", d, 8'h02);
      @(negedge clk);
      check("irq", {7'h00, irq}, 8'h00);
      host_u.wr(`PMSS_ADR_PWR, 8'h00);
      wait_irq(5000);
      check("ramp down", 8'(n >= (500 << t) - 6 && n <= (500 << t) + 6), 8'h01);
      host_u.rd(`PMSS_ADR_STAT, d);
      check("ready", d, 8'h01);
      host_u.rd(`PMSS_ADR_IRQ, d);
      check("irq flags", d, 8'h02);
    end
    host_u.wr(`PMSS_ADR_MOD3, 8'h00);
    // Automatic search: random stop, then floor
    for (int r = 0; r < 2; r++) begin
      lfsr = lfsr_next(lfsr);
      mm = lfsr[2:0];
      pm = lfsr[6:4];
      kk = (r == 0) ? int'(lfsr[10:8]) : -1;
      ex = (r == 0) ? lfsr[10:8] : 3'h0;
      host_u.wr(`PMSS_ADR_REG, {1'b0, pm, 1'b0, mm});
      host_u.cmd(`PMSS_CMD_AUTO);
      c0 = cyc;
      @(negedge clk);
      check("auto start", {2'b00, supply}, {2'b00, 3'h7, pm});
      @(negedge clk);
      check("field", {7'h00, field_on}, 8'h01);
      d = 8'h00;
      i = 0;
      while (d[`PMSS_IRQ_CMD] !== 1'b1 && i < 4) begin
        wait_irq(2000);
        host_u.rd(`PMSS_ADR_IRQ, d);
        i++;
      end
      check("cmd flag", {7'h00, d[`PMSS_IRQ_CMD]}, 8'h01);
      check("steps", 8'(cyc - c0 >= (8 - ex) * STEP), 8'h01);
      check("auto end", {2'b00, supply}, {2'b00, ex, (pm < ex) ? pm : ex});
      // A started ramp-up runs to its end before ramp-down begins
      repeat (1100) @(negedge clk);
      check("field off", {7'h00, field_on}, 8'h00);
      host_u.rd(`PMSS_ADR_IRQ, d);
      host_u.cmd(`PMSS_CMD_MAN);
      @(negedge clk);
      check("manual", {2'b00, supply}, {2'b00, mm, pm});
    end
    // Enable low in mid-search
    kk = -1;
    host_u.cmd(`PMSS_CMD_AUTO);
    repeat (STEP + 5) @(negedge clk);
    host_u.power_down();
    repeat (3) @(negedge clk);
    check("abort mode", {4'h0, mode}, {4'h0, pmss_pkg::pm_pdown});
    check("abort supply", {2'b00, supply}, 8'h3f);
    check("abort field", {7'h00, field_on}, 8'h00);
    host_u.power_up();
    host_u.rd(`PMSS_ADR_REG, d);
    check("reg cleared", d, `PMSS_RST_REG);
    give_verdict();
  end
endmodule
